//--- adc_seq_pkg.sv
// shared constants for the converter sequence ends
package adc_seq_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  // acquisition least time in ns (1.1 us)
  localparam int unsigned ACQ_TIME_NS      = 1100;
  localparam int unsigned ACQ_CYCLES       = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // conversion longest time (4.7 us)
  localparam int unsigned CONV_TIME_NS     = 4700;
  localparam int unsigned CONV_CYCLES      = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  // done-release and bus release longest time (40 ns)
  localparam int unsigned RELEASE_TIME_NS  = 40;
  localparam int unsigned RELEASE_CYCLES   = (RELEASE_TIME_NS * 1000) / CLK_PERIOD_PS;
  // strobe pulse least width (60 ns, low supply range)
  localparam int unsigned STROBE_TIME_NS   = 60;
  localparam int unsigned STROBE_CYCLES    = (STROBE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESULT_W         = 16;
  localparam int unsigned BYTE_W           = 8;
  localparam int unsigned CNT_W            = 11;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
endpackage

//--- adc_seq_if.sv
// pin-level link between the converter and its host
`timescale 1ns/1ps
`default_nettype none
interface adc_seq_if;
  logic                                   select_n;        // strobe, active low
  logic                                   read_convert;    // read high, convert low
  logic                                   upper_byte_select;
  logic                                   reset;           // full-width reset
  logic                                   done_n;          // conversion done, active low
  logic [adc_seq_pkg::RESULT_W-1:0]       result_bus_out;
  logic [adc_seq_pkg::RESULT_W-1:0]       result_bus_oe;
  logic [adc_seq_pkg::RESULT_W-1:0]       result_bus;      // resolved wire level
  assign result_bus = result_bus_out & result_bus_oe;
  modport device (input select_n, input read_convert, input upper_byte_select, input reset,
                  output done_n, output result_bus_out, output result_bus_oe);
  modport host   (output select_n, output read_convert, output upper_byte_select,
                  output reset, input done_n, input result_bus);
endinterface
`default_nettype wire

//--- adc_seq_device.sv
// converter end: strobe sequencing, timed conversion, three-state result bus
`timescale 1ns/1ps
`default_nettype none
module adc_seq_device #(
  parameter bit BYTE_WIDE = 1'b0                                      // byte-wide variant
) (
  input  wire logic                                SYS_CLK,           // system clock
  input  wire logic                                RESET,             // sync reset, high
  adc_seq_if.device                                LINK,              // pins toward host
  input  wire logic [adc_seq_pkg::RESULT_W-1:0]    SAMPLE_VALUE,      // value to convert
  output logic                                     POWERED,           // converter awake
  output logic                                     REF_ON,            // reference and buffer on
  output logic                                     CONVERTING         // conversion running
);
  typedef enum {ST_OFF, ST_ACQ, ST_CONV, ST_DONE, ST_READ} state_type;

  state_type                           state_q, state_d;
  logic                                sel_q, sel_d;
  logic [adc_seq_pkg::CNT_W-1:0]       cnt_q, cnt_d;
  logic                                shut_q, shut_d;
  logic                                ref_q, ref_d;
  logic [adc_seq_pkg::RESULT_W-1:0]    sample_q, sample_d;
  logic [adc_seq_pkg::RESULT_W-1:0]    result_q, result_d;
  logic                                done_n_q, done_n_d;
  logic                                drive_q, drive_d;
  logic [adc_seq_pkg::RESULT_W-1:0]    out_q, out_d;
  logic                                fall, rise, rst;
  logic                                conv_start, conv_end;
  // last timer count of a conversion: done falls CONV_CYCLES edges after the start
  localparam logic [adc_seq_pkg::CNT_W-1:0]    CONV_LAST =
    adc_seq_pkg::CNT_W'(adc_seq_pkg::CONV_CYCLES - 1);
  localparam logic [adc_seq_pkg::RESULT_W-1:0] OE_FULL   = 16'hffff;  // all sixteen lines
  localparam logic [adc_seq_pkg::RESULT_W-1:0] OE_BYTE   = 16'h00ff;  // low eight lines only

  function automatic logic [adc_seq_pkg::RESULT_W-1:0] present(
    input logic [adc_seq_pkg::RESULT_W-1:0] value,
    input logic                             upper
  );
    logic [adc_seq_pkg::BYTE_W-1:0] b;
    if (upper) begin
      b = value[adc_seq_pkg::RESULT_W-1 -: adc_seq_pkg::BYTE_W];
    end else begin
      b = value[adc_seq_pkg::BYTE_W-1:0];
    end
    // byte end: the unused upper lines read low
    present = {{adc_seq_pkg::BYTE_W{1'b0}}, b};
  endfunction

  // one decoder for both strobe edges, so fall and rise see the same levels
  function automatic logic strobe_edge(
    input logic prev,
    input logic now,
    input logic to_high
  );
    strobe_edge = to_high ? (!prev && now) : (prev && !now);
  endfunction

  assign rst        = RESET | (!BYTE_WIDE & LINK.reset);
  assign fall       = strobe_edge(sel_q, LINK.select_n, 1'b0);
  assign rise       = strobe_edge(sel_q, LINK.select_n, 1'b1);
  assign conv_start = (state_q == ST_ACQ) && fall;
  assign conv_end   = (state_q == ST_CONV) && (cnt_q == CONV_LAST);

  // strobe level seen at the previous edge
  always_comb begin
    sel_d = LINK.select_n;
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      sel_q <= 1'b1;                                                   // idle level: no rise after reset
    end else begin
      sel_q <= sel_d;
    end
  end

  // sequencer: power, reference, done flag and bus drive
  always_comb begin
    state_d  = state_q;
    shut_d   = shut_q;
    ref_d    = ref_q;
    done_n_d = done_n_q;
    drive_d  = drive_q;
    case (state_q)
      ST_OFF: begin
        if (fall && !LINK.read_convert) begin
          state_d  = ST_ACQ;
          ref_d    = 1'b1;
          done_n_d = 1'b1;
        end
      end
      ST_ACQ: begin
        if (conv_start) begin
          state_d = ST_CONV;
          shut_d  = LINK.read_convert;
        end
      end
      ST_CONV: begin
        if (conv_end) begin
          state_d  = ST_DONE;
          done_n_d = 1'b0;
          ref_d    = ~shut_q;
        end
      end
      ST_DONE: begin
        if (fall && LINK.read_convert) begin
          state_d = ST_READ;
          drive_d = 1'b1;
        end else if (fall) begin
          // a convert-low strobe skips the read and acquires again
          state_d  = ST_ACQ;
          ref_d    = 1'b1;
          done_n_d = 1'b1;
        end
      end
      ST_READ: begin
        if (rise) begin
          state_d  = ST_OFF;
          done_n_d = 1'b1;
          drive_d  = 1'b0;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      state_q  <= ST_OFF;
      shut_q   <= 1'b0;
      ref_q    <= 1'b0;
      done_n_q <= 1'b1;
      drive_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      shut_q   <= shut_d;
      ref_q    <= ref_d;
      done_n_q <= done_n_d;
      drive_q  <= drive_d;
    end
  end

  // conversion timer, paced by the system clock
  always_comb begin
    // counts from zero at the start strobe; conv_end marks the last count
    cnt_d = cnt_q;
    if (conv_start) begin
      cnt_d = '0;
    end else if (state_q == ST_CONV) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // held sample, finished result and the word put on the bus
  always_comb begin
    sample_d = conv_start ? SAMPLE_VALUE : sample_q;
    result_d = conv_end ? sample_q : result_q;
    out_d    = '0;
    if (drive_d) begin
      out_d = BYTE_WIDE ? present(result_d, LINK.upper_byte_select) : result_d;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      sample_q <= adc_seq_pkg::RESULT_RESET;
      result_q <= adc_seq_pkg::RESULT_RESET;
      out_q    <= adc_seq_pkg::RESULT_RESET;
    end else begin
      sample_q <= sample_d;
      result_q <= result_d;
      out_q    <= out_d;
    end
  end

  assign LINK.done_n         = done_n_q;
  assign LINK.result_bus_out = out_q;
  assign LINK.result_bus_oe  = drive_q ? (BYTE_WIDE ? OE_BYTE : OE_FULL) : 16'h0000;
  assign POWERED             = (state_q != ST_OFF);
  assign REF_ON              = ref_q;
  assign CONVERTING          = (state_q == ST_CONV);
endmodule
`default_nettype wire

//--- adc_seq_host.sv
// host end: strobe sequencer for acquire, convert and read
`timescale 1ns/1ps
`default_nettype none
module adc_seq_host #(
  parameter bit BYTE_WIDE = 1'b0                                      // byte-wide variant
) (
  input  wire logic                                SYS_CLK,           // system clock
  input  wire logic                                RESET,             // sync reset, high
  adc_seq_if.host                                  LINK,              // pins toward converter
  input  wire logic                                START,             // request a sample, pulse
  input  wire logic                                SHUTDOWN_AFTER,    // power down after conversion
  input  wire logic                                WAKE,              // take a dummy cycle first
  output logic                                     BUSY,              // sequence running
  output logic                                     RESULT_VALID,      // result pulse
  output logic [adc_seq_pkg::RESULT_W-1:0]         RESULT             // last result
);
  typedef enum {H_IDLE, H_ACQ, H_CONV, H_WAIT, H_READ, H_LOW2, H_REL} hstate_type;

  hstate_type                          state_q, state_d;
  logic [adc_seq_pkg::CNT_W-1:0]       cnt_q, cnt_d;
  logic                                sel_n_q, sel_n_d;
  logic                                rc_q, rc_d;
  logic                                hb_q, hb_d;
  logic                                dummy_q, dummy_d;
  logic                                shut_q, shut_d;
  logic                                valid_q, valid_d;
  logic [adc_seq_pkg::RESULT_W-1:0]    res_q, res_d;

  function automatic logic [adc_seq_pkg::CNT_W-1:0] sz(input int unsigned n);
    sz = adc_seq_pkg::CNT_W'(n);
  endfunction

  always_comb begin
    state_d = state_q;
    cnt_d   = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    sel_n_d = sel_n_q;
    rc_d    = rc_q;
    hb_d    = hb_q;
    dummy_d = dummy_q;
    shut_d  = shut_q;
    valid_d = 1'b0;
    res_d   = res_q;
    case (state_q)
      H_IDLE: begin
        if (START) begin
          dummy_d = WAKE;
          shut_d  = SHUTDOWN_AFTER;
          rc_d    = 1'b0;
          sel_n_d = 1'b0;
          cnt_d   = sz(adc_seq_pkg::ACQ_CYCLES);
          state_d = H_ACQ;
        end
      end
      H_ACQ: begin
        if (cnt_q <= sz(adc_seq_pkg::ACQ_CYCLES - adc_seq_pkg::STROBE_CYCLES)) begin
          sel_n_d = 1'b1;
        end
        if (cnt_q == '0) begin
          sel_n_d = 1'b0;
          rc_d    = shut_q;
          cnt_d   = sz(adc_seq_pkg::STROBE_CYCLES);
          state_d = H_CONV;
        end
      end
      H_CONV: begin
        if (cnt_q == '0) begin
          sel_n_d = 1'b1;
          rc_d    = 1'b1;
          state_d = H_WAIT;
        end
      end
      H_WAIT: begin
        if (!LINK.done_n) begin
          sel_n_d = 1'b0;
          hb_d    = 1'b0;
          cnt_d   = sz(adc_seq_pkg::STROBE_CYCLES + adc_seq_pkg::RELEASE_CYCLES);
          state_d = H_READ;
        end
      end
      H_READ: begin
        if (cnt_q == '0) begin
          res_d[7:0] = LINK.result_bus[7:0];
          if (!BYTE_WIDE) begin
            res_d[15:8] = LINK.result_bus[15:8];
            sel_n_d     = 1'b1;
            cnt_d       = sz(adc_seq_pkg::RELEASE_CYCLES + 1);
            state_d     = H_REL;
          end else begin
            hb_d    = 1'b1;
            cnt_d   = sz(adc_seq_pkg::RELEASE_CYCLES + 1);
            state_d = H_LOW2;
          end
        end
      end
      H_LOW2: begin
        if (cnt_q == '0) begin
          res_d[15:8] = LINK.result_bus[7:0];
          sel_n_d     = 1'b1;
          cnt_d       = sz(adc_seq_pkg::RELEASE_CYCLES + 1);
          state_d     = H_REL;
        end
      end
      H_REL: begin
        if (cnt_q == '0) begin
          if (dummy_q) begin
            dummy_d = 1'b0;
            rc_d    = 1'b0;
            sel_n_d = 1'b0;
            cnt_d   = sz(adc_seq_pkg::ACQ_CYCLES);
            state_d = H_ACQ;
          end else begin
            valid_d = 1'b1;
            state_d = H_IDLE;
          end
        end
      end
      default: state_d = H_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_q <= H_IDLE;
      cnt_q   <= '0;
      sel_n_q <= 1'b1;
      rc_q    <= 1'b0;
      hb_q    <= 1'b0;
      dummy_q <= 1'b0;
      shut_q  <= 1'b0;
      valid_q <= 1'b0;
      res_q   <= adc_seq_pkg::RESULT_RESET;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sel_n_q <= sel_n_d;
      rc_q    <= rc_d;
      hb_q    <= hb_d;
      dummy_q <= dummy_d;
      shut_q  <= shut_d;
      valid_q <= valid_d;
      res_q   <= res_d;
    end
  end

  assign LINK.select_n          = sel_n_q;
  assign LINK.read_convert      = rc_q;
  assign LINK.upper_byte_select = hb_q;
  assign LINK.reset             = RESET;
  assign BUSY                   = (state_q != H_IDLE);
  assign RESULT_VALID           = valid_q;
  assign RESULT                 = res_q;
endmodule
`default_nettype wire

//--- adc_seq_sva.sv
// concurrent checks on the link between converter and host ends
`timescale 1ns/1ps
`default_nettype none
module adc_seq_sva (
  input  wire logic                             SYS_CLK,       // system clock
  input  wire logic                             RESET,         // sync reset, high
  input  wire logic                             select_n,      // strobe, active low
  input  wire logic                             read_convert,  // read high, convert low
  input  wire logic                             done_n,        // conversion done, active low
  input  wire logic [adc_seq_pkg::RESULT_W-1:0] result_bus_oe  // per-bit bus enables
);
  localparam int CONV = adc_seq_pkg::CONV_CYCLES;
  logic        prev_q, prev_d, fall, acq_q, acq_d, conv_q, conv_d;
  logic [11:0] since_q, since_d;
  // tracks strobe falls, cycles since the last fall and the acquire/convert phase
  always_comb begin
    fall    = prev_q && !select_n;
    prev_d  = select_n;
    since_d = fall ? 12'h001 : ((since_q == 12'hfff) ? since_q : since_q + 12'h001);
    acq_d   = fall ? (!read_convert && !acq_q) : acq_q;
    conv_d  = (fall && acq_q) ? 1'b1 : ((done_n == 1'b0) ? 1'b0 : conv_q);
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      prev_q  <= 1'b1;
      since_q <= 12'h000;
      acq_q   <= 1'b0;
      conv_q  <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      since_q <= since_d;
      acq_q   <= acq_d;
      conv_q  <= conv_d;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence s_read_fall;
    fall && read_convert && !done_n;
  endsequence
  sequence s_read_rise;
    $rose(select_n) && (|result_bus_oe);
  endsequence
  a_read_drive: assert property (s_read_fall |=> result_bus_oe == '1)
    else $error("bus not driven on all lines after read strobe");
  a_bus_release: assert property (|result_bus_oe |-> !$past(select_n))
    else $error("bus driven while strobe high");
  a_done_release: assert property (s_read_rise |=> done_n && result_bus_oe == '0)
    else $error("done or bus not released after read");
  a_done_hold: assert property (!done_n && !$rose(select_n) && !(fall && !read_convert) |=> !done_n)
    else $error("done dropped without read");
  a_conv_time: assert property ($fell(done_n) |-> since_q inside {[CONV:CONV+1]})
    else $error("conversion length wrong");
  a_acq_time: assert property (fall && acq_q |-> since_q >= adc_seq_pkg::ACQ_CYCLES)
    else $error("acquisition too short");
  a_no_early: assert property (fall |-> !conv_q)
    else $error("strobe fell during conversion");
  a_bus_gap: assert property (s_read_rise |=> select_n [*8] ##1 select_n [*2])
    else $error("new strobe inside bus release time");
  a_reset_idle: assert property ($fell(RESET) |-> done_n && result_bus_oe == '0)
    else $error("link not idle after reset");
endmodule
`default_nettype wire

//--- tb_parallel_sar_adc_host_sequence.sv
// testbench: host and converter ends back to back, plus a byte-wide end on a hand driver
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_sar_adc_host_sequence;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  logic        shutdown_after = 1'b0;
  logic        wake = 1'b0;
  logic [15:0] sample_a = 16'h0000;
  logic [15:0] sample_b = 16'h0000;
  logic        busy, result_valid, powered_a, ref_on_a, conv_a, powered_b, ref_on_b, conv_b;
  logic [15:0] result;
  logic [15:0] exp_q[$];
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  adc_seq_if link_a ();
  adc_seq_if link_b ();
  adc_seq_device #(.BYTE_WIDE(1'b0)) adc_seq_device_inst (.SYS_CLK(sys_clk), .RESET(reset),
    .LINK(link_a), .SAMPLE_VALUE(sample_a), .POWERED(powered_a), .REF_ON(ref_on_a),
    .CONVERTING(conv_a));
  adc_seq_host #(.BYTE_WIDE(1'b0)) adc_seq_host_inst (.SYS_CLK(sys_clk), .RESET(reset),
    .LINK(link_a), .START(start), .SHUTDOWN_AFTER(shutdown_after), .WAKE(wake),
    .BUSY(busy), .RESULT_VALID(result_valid), .RESULT(result));
  adc_seq_device #(.BYTE_WIDE(1'b1)) adc_seq_device_b_inst (.SYS_CLK(sys_clk), .RESET(reset),
    .LINK(link_b), .SAMPLE_VALUE(sample_b), .POWERED(powered_b), .REF_ON(ref_on_b),
    .CONVERTING(conv_b));
  adc_seq_sva adc_seq_sva_inst (.SYS_CLK(sys_clk), .RESET(reset), .select_n(link_a.select_n),
    .read_convert(link_a.read_convert), .done_n(link_a.done_n),
    .result_bus_oe(link_a.result_bus_oe));
  always #2 sys_clk = ~sys_clk;
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one host request; the model queue holds the value the host must hand back
  task automatic host_sample(input logic sd, input logic wk);
    int          n;
    int          conv_n;
    logic        saw_pwr;
    logic [15:0] v;
    n = 0;
    conv_n = 0;
    saw_pwr = 1'b0;
    v = 16'($urandom);
    @(posedge sys_clk);
    sample_a <= v;
    shutdown_after <= sd;
    wake <= wk;
    start <= 1'b1;
    exp_q.push_back(v);
    @(posedge sys_clk);
    start <= 1'b0;
    while (result_valid !== 1'b1 && n < 8000) begin
      @(negedge sys_clk);
      n++;
      if (conv_a === 1'b1) conv_n++;
      if (powered_a === 1'b1) saw_pwr = 1'b1;
    end
    check(result, exp_q.pop_front());
    check(saw_pwr, 1'b1);
    check(16'(conv_n), 16'((wk ? 2 : 1) * adc_seq_pkg::CONV_CYCLES));
    check(ref_on_a, !sd);
  endtask
  // strobe on the byte-wide end, held low for the given number of cycles
  task automatic strobe_b(input logic rc, input int low);
    @(posedge sys_clk);
    link_b.select_n <= 1'b0;
    link_b.read_convert <= rc;
    repeat (low) @(posedge sys_clk);
    link_b.select_n <= 1'b1;
  endtask
  task automatic byte_run();
    int n;
    n = 0;
    @(posedge sys_clk) sample_b <= 16'($urandom);
    strobe_b(1'b1, 15);
    @(negedge sys_clk) check(powered_b, 1'b0);
    strobe_b(1'b0, 15);
    @(negedge sys_clk) check(powered_b, 1'b1);
    repeat (275) @(posedge sys_clk);
    strobe_b(1'b1, 15);
    @(negedge sys_clk) check(conv_b, 1'b1);
    while (link_b.done_n !== 1'b0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check(link_b.done_n, 1'b0);
    @(posedge sys_clk);
    link_b.select_n <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check(link_b.result_bus, {8'h00, sample_b[7:0]});
    @(posedge sys_clk) link_b.upper_byte_select <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check(link_b.result_bus, {8'h00, sample_b[15:8]});
    @(posedge sys_clk) link_b.select_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check(link_b.done_n, 1'b1);
    check(link_b.result_bus_oe, 16'h0000);
    check(ref_on_b, 1'b0);
  endtask
  initial begin
    int seed;
    int n;
    seed = $urandom(32'h9790fbb2);
    link_b.select_n = 1'b1;
    link_b.read_convert = 1'b0;
    link_b.upper_byte_select = 1'b0;
    link_b.reset = 1'b0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    host_sample(1'b0, 1'b0);
    host_sample(1'b1, 1'b0);
    host_sample(1'b0, 1'b1);
    host_sample(1'b1, 1'b1);
    byte_run();
    // reset in mid-conversion
    n = 0;
    @(posedge sys_clk) start <= 1'b1;
    @(posedge sys_clk) start <= 1'b0;
    while (conv_a !== 1'b1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk) reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check(link_a.done_n, 1'b1);
    check(link_a.result_bus_oe, 16'h0000);
    check(busy, 1'b0);
    host_sample(1'b0, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
